// ### hdl/timer_counter_capture.sv
// 8-bit timer, event counter and capture unit behind an APB slave
//
// Notes on behaviour
// - Timer mode: count ticks, match A clears, interrupt
// - Auto-capture copies running count into B
// - Zero after match clear never copied into B
// - Clock select picks prescaler tap, fast-only codes
// - Event mode counts rising edges of event pin
// - Event mode match checked on falling edge
// - Capture: first falling edge copies count into B
// - Capture: rising edge loads A, interrupt, clear
// - After clear, next falling edge recaptures into B
// - Rising edge first: only A, B kept
// - Capture overflow: interrupt, A all ones, clear
// - After overflow capture suspended until A read
// - Stop power mode clears run control
// - Auto-capture ignored in capture mode
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module timer_counter_capture (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire timer_capture_pkg::apb_req_t apb_in,
	output timer_capture_pkg::apb_rsp_t apb_out,
	input wire logic event_pin_in,
	input wire logic low_osc_tick_in,
	input wire logic prescale_slow_sel_in,
	input wire logic prescale_half_sel_in,
	input wire logic low_speed_mode_in,
	input wire logic stop_enter_in,
	output logic timer_irq_out
);
	import timer_capture_pkg::*;

	// True when the low k bits of a divider are all ones
	function automatic logic tap_hit(input logic [DIV_WIDTH-1:0] div,
			input logic [3:0] k);
		logic [DIV_WIDTH:0] mask;
		mask = (17'h00001 << k) - 17'h00001;
		return &(div | ~mask[DIV_WIDTH-1:0]);
	endfunction

	logic [7:0] cmp_a_q, cmp_a_d;
	logic [7:0] cap_b_q, cap_b_d;
	logic [7:0] count_q, count_d;
	logic run_q, run_d;
	logic auto_capture_en_q;
	logic [2:0] clk_sel_q;
	mode_t mode_q;
	logic armed_q, armed_d;
	logic hold_q, hold_d;
	logic irq_q, irq_d;
	logic [DIV_WIDTH-1:0] fdiv_q, sdiv_q;
	logic sync1_q, sync2_q, sync3_q, level_q;
	logic [31:0] prdata_q;
	logic slverr_q;

	// Bus decode
	wire setup = apb_in.psel & ~apb_in.penable;
	wire access = apb_in.psel & apb_in.penable;
	wire hit_a = apb_in.paddr == ADDR_COMPARE_CAPTURE_A;
	wire hit_b = apb_in.paddr == ADDR_CAPTURE_REG_B;
	wire hit_ctrl = apb_in.paddr == ADDR_TIMER_CTRL_REG;
	wire mapped = hit_a | hit_b | hit_ctrl;
	wire wr_ok = access & apb_in.pwrite & mapped;
	wire wr_a = wr_ok & hit_a;
	wire wr_ctrl = wr_ok & hit_ctrl;
	wire rd_a = access & ~apb_in.pwrite & hit_a;
	wire [7:0] ctrl_view = {1'b0, auto_capture_en_q, 1'b0, run_q, clk_sel_q, mode_q};

	assign apb_out.prdata = prdata_q;
	assign apb_out.pready = 1'b1;
	assign apb_out.pslverr = slverr_q;
	assign timer_irq_out = irq_q;

	// Event pin: a change counts once the second and third stages agree
	wire pin_agree = sync2_q == sync3_q;
	wire pin_rise = pin_agree & sync3_q & ~level_q;
	wire pin_fall = pin_agree & ~sync3_q & level_q;

	// Prescaler tap selection
	wire ext_sel = clk_sel_q == CODE_EXTERNAL;
	wire fast_only = clk_sel_q >= CODE_FAST_ONLY;
	wire use_slow = (prescale_slow_sel_in | low_speed_mode_in) & ~fast_only;
	wire [3:0] fast_k = FAST_BASE_EXP - {1'b0, clk_sel_q}
		+ {3'h0, prescale_half_sel_in};
	wire [3:0] slow_k = SLOW_BASE_EXP - {1'b0, clk_sel_q};
	wire tap_ok = ~(low_speed_mode_in & fast_only);
	wire slow_tick = low_osc_tick_in & tap_hit(sdiv_q, slow_k);
	wire fast_tick = tap_hit(fdiv_q, fast_k);
	wire int_tick = tap_ok & (use_slow ? slow_tick : fast_tick);
	wire src_tick = ext_sel ? pin_rise : int_tick;

	wire timer_mode = mode_q == MODE_TIMER_EVENT;
	wire match = count_q == cmp_a_q;
	// Timer matches on a tick; event counting matches on a falling edge
	wire tm_match = timer_mode & (ext_sel ? pin_fall : src_tick) & match;
	wire cap_rise = ~timer_mode & armed_q & pin_rise;
	wire cap_fall = ~timer_mode & armed_q & pin_fall;
	wire cap_over = ~timer_mode & armed_q & src_tick & ~pin_rise
		& (count_q == COUNT_FULL);

	// Counter, captures and interrupt
	always_comb begin
		count_d = count_q;
		cmp_a_d = cmp_a_q;
		cap_b_d = cap_b_q;
		armed_d = armed_q;
		hold_d = hold_q;
		irq_d = 1'b0;
		run_d = run_q;
		if (wr_ctrl) begin
			run_d = apb_in.pwdata[CTRL_RUN_BIT];
		end
		if (stop_enter_in) begin
			run_d = 1'b0;
		end
		if (wr_a) begin
			cmp_a_d = apb_in.pwdata[7:0];
		end
		if (!run_q) begin
			count_d = RESET_COUNT;
			armed_d = 1'b1;
			hold_d = 1'b0;
		end else if (timer_mode) begin
			if (tm_match) begin
				count_d = RESET_COUNT;
				irq_d = 1'b1;
				hold_d = 1'b1;
			end else if (src_tick) begin
				count_d = count_q + 8'h01;
				hold_d = 1'b0;
			end
			// Zero left by a match clear stays out of B
			if (auto_capture_en_q && !hold_q) begin
				cap_b_d = count_q;
			end
		end else begin
			// Auto-capture has no path here
			if (src_tick) begin
				count_d = count_q + 8'h01;
			end
			if (cap_fall) begin
				cap_b_d = count_q;
			end
			if (cap_rise) begin
				cmp_a_d = count_q;
				count_d = RESET_COUNT;
				irq_d = 1'b1;
			end else if (cap_over) begin
				cmp_a_d = COUNT_FULL;
				count_d = RESET_COUNT;
				irq_d = 1'b1;
				armed_d = 1'b0;
			end
			// The re-arm read only acts while disarmed, so an A read in the overflow cycle still leaves armed cleared
			if (rd_a && !armed_q) begin
				armed_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			sync1_q <= event_pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (pin_agree) begin
				level_q <= sync3_q;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fdiv_q <= '0;
			sdiv_q <= '0;
		end else begin
			fdiv_q <= fdiv_q + 16'h0001;
			if (low_osc_tick_in) begin
				sdiv_q <= sdiv_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_q <= RESET_COUNT;
			cmp_a_q <= RESET_A;
			cap_b_q <= RESET_B;
			run_q <= 1'b0;
			armed_q <= 1'b1;
			hold_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			count_q <= count_d;
			cmp_a_q <= cmp_a_d;
			cap_b_q <= cap_b_d;
			run_q <= run_d;
			armed_q <= armed_d;
			hold_q <= hold_d;
			irq_q <= irq_d;
		end
	end

	// Mode and clock fields are expected to change only while stopped
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			auto_capture_en_q <= 1'b0;
			clk_sel_q <= 3'h0;
			mode_q <= MODE_TIMER_EVENT;
		end else if (wr_ctrl) begin
			auto_capture_en_q <= apb_in.pwdata[CTRL_AUTO_CAPTURE_EN_BIT];
			clk_sel_q <= apb_in.pwdata[CTRL_CLK_LSB+:3];
			mode_q <= mode_t'(apb_in.pwdata[CTRL_MODE_BIT]);
		end
	end

	// Read data is latched in the setup cycle so the answer is a flop
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prdata_q <= 32'h00000000;
			slverr_q <= 1'b0;
		end else if (setup) begin
			slverr_q <= ~mapped;
			prdata_q <= {24'h000000, hit_a ? cmp_a_q :
				hit_b ? cap_b_q : hit_ctrl ? ctrl_view : 8'h00};
		end
	end

	property p_timer_match;
		@(posedge clk_in) disable iff (reset_in)
		run_q && timer_mode && !ext_sel && src_tick && match
		|=> timer_irq_out && count_q == 8'h00;
	endproperty
	a_timer_match: assert property (p_timer_match)
		else $error("timer match did not clear and interrupt");

	property p_autocap;
		@(posedge clk_in) disable iff (reset_in)
		run_q && timer_mode && auto_capture_en_q && !hold_q
		|=> cap_b_q == $past(count_q);
	endproperty
	a_autocap: assert property (p_autocap)
		else $error("auto-capture did not follow count");

	property p_no_zero;
		@(posedge clk_in) disable iff (reset_in)
		timer_irq_out && timer_mode && auto_capture_en_q && run_q
		|-> $stable(cap_b_q) ##1 $stable(cap_b_q) || !hold_q;
	endproperty
	a_no_zero: assert property (p_no_zero)
		else $error("zero after match clear reached B");

	property p_tap;
		@(posedge clk_in) disable iff (reset_in)
		low_speed_mode_in && fast_only |-> !int_tick;
	endproperty
	a_tap: assert property (p_tap)
		else $error("fast-only tap ticked in low-speed mode");

	property p_event_count;
		@(posedge clk_in) disable iff (reset_in)
		run_q && timer_mode && ext_sel && pin_rise
		|=> count_q == $past(count_q) + 8'h01;
	endproperty
	a_event_count: assert property (p_event_count)
		else $error("event rising edge not counted");

	property p_event_match;
		@(posedge clk_in) disable iff (reset_in)
		run_q && timer_mode && ext_sel && match && !pin_fall
		|=> !timer_irq_out;
	endproperty
	a_event_match: assert property (p_event_match)
		else $error("event match fired without falling edge");

	property p_cap_fall;
		@(posedge clk_in) disable iff (reset_in)
		run_q && cap_fall |=> cap_b_q == $past(count_q);
	endproperty
	a_cap_fall: assert property (p_cap_fall)
		else $error("falling edge not captured into B");

	property p_cap_rise;
		@(posedge clk_in) disable iff (reset_in)
		run_q && cap_rise && !cap_fall
		|=> cmp_a_q == $past(count_q) && timer_irq_out && count_q == 8'h00
			&& $stable(cap_b_q);
	endproperty
	a_cap_rise: assert property (p_cap_rise)
		else $error("rising edge capture into A wrong");

	property p_overflow;
		@(posedge clk_in) disable iff (reset_in)
		run_q && cap_over
		|=> cmp_a_q == 8'hFF && timer_irq_out && !armed_q;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow handling wrong");

	property p_rearm;
		@(posedge clk_in) disable iff (reset_in)
		!armed_q && !timer_mode && run_q && pin_rise && !rd_a
		|=> !timer_irq_out ##0 !armed_q;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("capture acted while suspended");

	property p_stop;
		@(posedge clk_in) disable iff (reset_in)
		stop_enter_in |=> !run_q ##1 count_q == 8'h00;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop mode did not halt the timer");
endmodule

// ### hdl/timer_capture_pkg.sv
// Package with register map, field layout and shared types of the timer
package timer_capture_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_COMPARE_CAPTURE_A = 8'h10;
	localparam logic [7:0] IDX_CAPTURE_REG_B = 8'h11;
	localparam logic [7:0] IDX_TIMER_CTRL_REG = 8'h12;
	localparam logic [11:0] ADDR_COMPARE_CAPTURE_A =
		{2'h0, IDX_COMPARE_CAPTURE_A, 2'h0};
	localparam logic [11:0] ADDR_CAPTURE_REG_B =
		{2'h0, IDX_CAPTURE_REG_B, 2'h0};
	localparam logic [11:0] ADDR_TIMER_CTRL_REG =
		{2'h0, IDX_TIMER_CTRL_REG, 2'h0};

	// Control register fields
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_CLK_LSB = 1;
	localparam int CTRL_RUN_BIT = 4;
	localparam int CTRL_AUTO_CAPTURE_EN_BIT = 6;

	// Reset values
	localparam logic [7:0] RESET_A = 8'hFF;
	localparam logic [7:0] RESET_B = 8'hFF;
	localparam logic [7:0] RESET_COUNT = 8'h00;
	localparam logic [7:0] COUNT_FULL = 8'hFF;

	// Prescaler taps: code n picks main_osc/2^(13-n) or low_osc/2^(5-n)
	localparam logic [3:0] FAST_BASE_EXP = 4'hD;
	localparam logic [3:0] SLOW_BASE_EXP = 4'h5;
	localparam logic [2:0] CODE_FAST_ONLY = 3'h5;
	localparam logic [2:0] CODE_EXTERNAL = 3'h7;
	localparam int DIV_WIDTH = 16;

	// Event pin: high and low phases each at least four main clock periods
	localparam int MIN_PHASE_PERIODS = 4;

	typedef enum logic [0:0] {
		MODE_TIMER_EVENT = 1'b0,
		MODE_CAPTURE = 1'b1
	} mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage

// ### verification/event_source.sv
// Model of the external pulse source on the timer's event pin
`timescale 1ns/1ps
module event_source (
	input wire logic clk_in,
	output logic event_pin_out
);
	initial event_pin_out = 1'b0;
	// Short phases would be lost in the pin synchroniser, so a floor of
	// four clocks is kept whatever the caller asks for
	task automatic drive(input logic level, input int hold);
		@(posedge clk_in);
		event_pin_out <= level;
		repeat ((hold > 4) ? hold : 4) @(posedge clk_in);
	endtask
endmodule

// ### verification/timer_counter_capture_tb.sv
// Self-checking bench for the 8-bit timer, event counter and capture unit
`timescale 1ns/1ps
module timer_counter_capture_tb;
	import timer_capture_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	apb_req_t apb_in = '0;
	apb_rsp_t apb_out;
	logic low_speed_in = 1'b0;
	logic stop_in = 1'b0;
	logic event_pin;
	logic irq;
	int miscompares = 0;
	int n_tests = 0;
	int irqs = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;

	timer_counter_capture timer_counter_capture_inst (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.apb_in(apb_in),
		.apb_out(apb_out),
		.event_pin_in(event_pin),
		.low_osc_tick_in(1'b0),
		.prescale_slow_sel_in(1'b0),
		.prescale_half_sel_in(1'b0),
		.low_speed_mode_in(low_speed_in),
		.stop_enter_in(stop_in),
		.timer_irq_out(irq)
	);
	event_source event_source_inst (
		.clk_in(clk_in),
		.event_pin_out(event_pin)
	);

	initial begin
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (irq === 1'b1)
			irqs <= irqs + 1;
	end

	task automatic conclude();
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, seen);
			miscompares++;
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int i;
		@(posedge clk_in);
		apb_in <= {1'b1, 1'b0, wr, a, wd};
		@(posedge clk_in);
		apb_in.penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (apb_out.pready === 1'b1)
				break;
		end
		rd = apb_out.prdata;
		err = apb_out.pslverr;
		apb_in.psel <= 1'b0;
		apb_in.penable <= 1'b0;
		if (i == 20) begin
			miscompares++;
			conclude();
		end
	endtask

	task automatic rchk(input string w, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(w, rd, e);
	endtask

	task automatic wait_irq(input int limit);
		int n0;
		n0 = irqs;
		repeat (limit) begin
			@(posedge clk_in);
			if (irqs != n0)
				return;
		end
		miscompares++;
		conclude();
	endtask

	// Mode and compare value only change with the counter stopped
	task automatic start(input logic [7:0] a, input logic [7:0] cfg);
		apb(1'b1, ADDR_TIMER_CTRL_REG, 32'h0);
		apb(1'b1, ADDR_COMPARE_CAPTURE_A, {24'h0, a});
		apb(1'b1, ADDR_TIMER_CTRL_REG, {24'h0, cfg});
		apb(1'b1, ADDR_TIMER_CTRL_REG, {24'h0, cfg | 8'h10});
	endtask

	task automatic pin(input logic l, input int h);
		event_source_inst.drive(l, h);
	endtask

	task automatic reg_check();
		rchk("a_rst", ADDR_COMPARE_CAPTURE_A, 32'hFF);
		rchk("b_rst", ADDR_CAPTURE_REG_B, 32'hFF);
		rchk("ctl_rst", ADDR_TIMER_CTRL_REG, 32'h0);
		apb(1'b1, ADDR_CAPTURE_REG_B, 32'h55);
		rchk("b_ro", ADDR_CAPTURE_REG_B, 32'hFF);
		apb(1'b1, ADDR_COMPARE_CAPTURE_A, 32'h5A);
		rchk("a_rw", ADDR_COMPARE_CAPTURE_A, 32'h5A);
		apb(1'b1, ADDR_TIMER_CTRL_REG, 32'hAF);
		rchk("ctl_rsv", ADDR_TIMER_CTRL_REG, 32'h0F);
		apb(1'b0, 12'h100, 32'h0);
		check("unm_err", {31'h0, err}, 32'h1);
		check("unm_data", rd, 32'h0);
	endtask

	// Code 6 ticks every 128 clocks; a period is count 0, 1 then A, three ticks
	task automatic timer_mode();
		int t0;
		start(8'h02, 8'h4C);
		wait_irq(600);
		t0 = cyc;
		wait_irq(600);
		check("period", cyc - t0, 32'd384);
		rchk("b_match", ADDR_CAPTURE_REG_B, 32'h2);
		low_speed_in <= 1'b1;
		start(8'h02, 8'h0C);
		t0 = irqs;
		repeat (1000) @(posedge clk_in);
		check("slow_tap", irqs - t0, 32'h0);
		low_speed_in <= 1'b0;
		wait_irq(600);
	endtask

	task automatic event_mode();
		int n0;
		start(8'h03, 8'h4E);
		n0 = irqs;
		pin(1'b1, 8);
		pin(1'b0, 8);
		pin(1'b1, 8);
		pin(1'b0, 8);
		rchk("b_evt", ADDR_CAPTURE_REG_B, 32'h2);
		pin(1'b1, 8);
		check("irq_rise", irqs - n0, 32'h0);
		pin(1'b0, 8);
		check("irq_fall", irqs - n0, 32'h1);
		rchk("b_zero", ADDR_CAPTURE_REG_B, 32'h3);
		pin(1'b1, 8);
		pin(1'b0, 8);
		rchk("b_clr", ADDR_CAPTURE_REG_B, 32'h1);
	endtask

	// Prescaler phase is free, so captured counts are checked to one tick
	task automatic capture_mode();
		int n0;
		logic [31:0] b0;
		apb(1'b0, ADDR_CAPTURE_REG_B, 32'h0);
		b0 = rd;
		start(8'h00, 8'h4D);
		repeat (384) @(posedge clk_in);
		n0 = irqs;
		pin(1'b1, 640);
		check("irq_1st", irqs - n0, 32'h1);
		rchk("b_kept", ADDR_CAPTURE_REG_B, b0);
		apb(1'b0, ADDR_COMPARE_CAPTURE_A, 32'h0);
		check("a_1st", rd >= 2 && rd <= 4, 32'h1);
		pin(1'b0, 640);
		pin(1'b1, 640);
		apb(1'b0, ADDR_CAPTURE_REG_B, 32'h0);
		b0 = rd;
		check("b_low", rd >= 4 && rd <= 6, 32'h1);
		apb(1'b0, ADDR_COMPARE_CAPTURE_A, 32'h0);
		check("a_per", rd >= 9 && rd <= 11, 32'h1);
		wait_irq(34000);
		n0 = irqs;
		// Each phase outlasts one 128-clock source tick
		pin(1'b0, 160);
		pin(1'b1, 160);
		check("susp_irq", irqs - n0, 32'h0);
		rchk("susp_b", ADDR_CAPTURE_REG_B, b0);
		rchk("a_ovf", ADDR_COMPARE_CAPTURE_A, 32'hFF);
		pin(1'b0, 160);
		pin(1'b1, 160);
		check("rearm", irqs - n0, 32'h1);
		stop_in <= 1'b1;
		@(posedge clk_in);
		stop_in <= 1'b0;
		rchk("stop", ADDR_TIMER_CTRL_REG, 32'h4D);
	endtask

	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		reg_check();
		timer_mode();
		event_mode();
		capture_mode();
		conclude();
	end
endmodule
